// File: shared/difm_pkg.sv
// constants and types for the digital input function map
package difm_pkg;
	localparam int NUM_TERM = 8;
	localparam int CODE_W   = 6;

	typedef logic [CODE_W-1:0] difm_code_t;
	typedef enum logic [1:0] {DIFM_POS, DIFM_SPD, DIFM_TRQ} difm_mode_t;

	localparam difm_code_t FC_DISABLED  = 6'h00;
	localparam difm_code_t FC_SERVO_ON  = 6'h01;
	localparam difm_code_t FC_FAULT_CLR = 6'h02;
	localparam difm_code_t FC_POS_CLR   = 6'h03;
	localparam difm_code_t FC_SPD_DIR   = 6'h04;
	localparam difm_code_t FC_CMD0      = 6'h05;
	localparam difm_code_t FC_CMD_TRIG  = 6'h09;
	localparam difm_code_t FC_MODE_SW   = 6'h0A;
	localparam difm_code_t FC_ZERO_HOLD = 6'h0B;
	localparam difm_code_t FC_PUL_INH   = 6'h0C;
	localparam difm_code_t FC_FWD_INH   = 6'h0D;
	localparam difm_code_t FC_REV_INH   = 6'h0E;
	localparam difm_code_t FC_GAIN_SEL  = 6'h0F;
	localparam difm_code_t FC_INERT_SEL = 6'h10;
	localparam difm_code_t FC_JOG_FWD   = 6'h11;
	localparam difm_code_t FC_JOG_REV   = 6'h12;
	localparam difm_code_t FC_TRQ_DIR   = 6'h13;
	localparam difm_code_t FC_GEAR0     = 6'h14;
	localparam difm_code_t FC_GEAR1     = 6'h15;
	localparam difm_code_t FC_EXT_DET   = 6'h16;
	localparam difm_code_t FC_HOME      = 6'h17;
	localparam difm_code_t FC_TRQ_LIM   = 6'h18;
	localparam difm_code_t FC_ESTOP     = 6'h19;
	localparam difm_code_t FC_POS_DIR   = 6'h21;
	localparam difm_code_t FC_PROBE     = 6'h22;
	localparam difm_code_t FC_FWD_OFS   = 6'h23;
	localparam difm_code_t FC_REV_OFS   = 6'h24;

	// terminal 8 in the top field, terminal 1 in the bottom field
	localparam logic [NUM_TERM*CODE_W-1:0] DEF_CODES = {
		6'h15, 6'h14, 6'h0C, 6'h03, 6'h0E, 6'h0D, 6'h02, 6'h01};

	localparam int MODE_OFF_LSB = 0;
	localparam int MODE_ON_LSB  = 2;
	localparam difm_mode_t RST_MODE = DIFM_POS;
endpackage : difm_pkg

// File: design/difm_edge_det.sv
// terminal sampling and edge detection
module difm_edge_det (
	input  wire logic                          clk_in,
	input  wire logic                          rst_b_in,
	input  wire logic [difm_pkg::NUM_TERM-1:0] term_in,
	output logic      [difm_pkg::NUM_TERM-1:0] lvl_out,
	output logic      [difm_pkg::NUM_TERM-1:0] rise_out,
	output logic      [difm_pkg::NUM_TERM-1:0] fall_out
);
	import difm_pkg::*;

	logic [NUM_TERM-1:0] sample_r;
	logic [NUM_TERM-1:0] prev_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sample_r <= '0;
			prev_r   <= '0;
		end else begin
			sample_r <= term_in;
			prev_r   <= sample_r;
		end
	end

	assign lvl_out  = sample_r;
	assign rise_out = sample_r & ~prev_r; // RULE12
	assign fall_out = ~sample_r & prev_r; // RULE12
endmodule // difm_edge_det

// File: design/difm_top.sv
// digital input terminal to drive function mapping
// How it works
// RULE1: each terminal holds a function code; code 0 drives nothing.
// RULE2: code 2 clears resettable faults on inactive-to-active edge, all modes.
// RULE3: code 4 level reverses speed command direction, speed mode only.
// RULE4: code 10 level picks control mode via mode selection parameter.
// RULE5: code 11 level enables zero speed hold, speed mode only.
// RULE6: code 19 level inverts torque direction, torque mode only.
// RULE7: code 33 level makes position direction negative, position mode only.
// RULE8: code 34 edge performs position probe capture in all modes.
// RULE9: code 35 rising edge gives forward pulse offset, position mode only.
// RULE10: code 36 rising edge gives reverse pulse offset, position mode only.
// RULE11: eight terminals defaulting to codes 1,2,13,14,3,12,20,21.
// RULE12: edges found by comparing sample to previous sample, one-cycle pulse.
// RULE13: level functions follow the sampled terminal level every cycle.
module difm_top (
	input  wire logic                          clk_in,
	input  wire logic                          rst_b_in,
	input  wire logic [difm_pkg::NUM_TERM-1:0] input_terminal_in,
	input  wire logic                          code_wr_in,
	input  wire logic [2:0]                    code_idx_in,
	input  wire difm_pkg::difm_code_t          code_data_in,
	input  wire logic [3:0]                    mode_select_param_in,
	input  wire logic                          pos_clear_level_in,
	output difm_pkg::difm_code_t               code_rd_out,
	output difm_pkg::difm_mode_t               ctrl_mode_out,
	output logic                               servo_enable_out,
	output logic                               fault_clear_out,
	output logic                               pos_err_clear_out,
	output logic                               speed_dir_invert_out,
	output logic [3:0]                         internal_cmd_out,
	output logic                               cmd_trigger_out,
	output logic                               zero_speed_hold_out,
	output logic                               pulse_inhibit_out,
	output logic                               fwd_inhibit_out,
	output logic                               rev_inhibit_out,
	output logic                               gain_sel_out,
	output logic                               inertia_sel_out,
	output logic                               jog_fwd_out,
	output logic                               jog_rev_out,
	output logic                               torque_dir_invert_out,
	output logic [1:0]                         gear_num_sel_out,
	output logic                               ext_det_rise_out,
	output logic                               ext_det_fall_out,
	output logic                               home_start_out,
	output logic                               torque_limit_out,
	output logic                               estop_out,
	output logic                               pos_dir_invert_out,
	output logic                               probe_capture_out,
	output logic                               fwd_offset_out,
	output logic                               rev_offset_out
);
	import difm_pkg::*;

	logic [NUM_TERM*CODE_W-1:0] codes_r;
	logic [NUM_TERM-1:0]        lvl;
	logic [NUM_TERM-1:0]        rise;
	logic [NUM_TERM-1:0]        fall;
	difm_mode_t                 mode_r;
	difm_mode_t                 mode_nxt;
	logic                       in_p;
	logic                       in_s;
	logic                       in_t;

	// several terminals may share a code; their contributions are or-ed
	function automatic logic hit(input logic [NUM_TERM-1:0]        v,
	                             input logic [NUM_TERM*CODE_W-1:0] codes,
	                             input difm_code_t                 fc);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++) begin
			if (fc != FC_DISABLED && codes[i*CODE_W +: CODE_W] == fc) begin // RULE1
				r = r | v[i];
			end
		end
		return r;
	endfunction

	// an unused mode encoding falls back to position control
	function automatic difm_mode_t to_mode(input logic [1:0] f);
		difm_mode_t m;
		m = DIFM_POS;
		case (f)
			2'h1: m = DIFM_SPD;
			2'h2: m = DIFM_TRQ;
			default: m = DIFM_POS;
		endcase
		return m;
	endfunction

	difm_edge_det u_edge (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.term_in  (input_terminal_in),
		.lvl_out  (lvl),
		.rise_out (rise),
		.fall_out (fall)
	);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			codes_r <= DEF_CODES; // RULE11
		end else begin
			for (int i = 0; i < NUM_TERM; i++) begin
				if (code_wr_in && code_idx_in == 3'(i)) begin
					codes_r[i*CODE_W +: CODE_W] <= code_data_in; // RULE1
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_rd_out <= FC_DISABLED;
		end else begin
			code_rd_out <= codes_r[code_idx_in*CODE_W +: CODE_W];
		end
	end

	logic h_sw_any;
	logic h_sw;
	logic h_son;
	logic h_spd_dir;
	logic h_zhold;
	logic h_trq_dir;
	logic h_pos_dir;
	logic h_fault_rise;
	logic h_probe_rise;
	logic h_fwd_rise;
	logic h_rev_rise;

	assign h_sw_any     = hit({NUM_TERM{1'b1}}, codes_r, FC_MODE_SW);
	assign h_sw         = hit(lvl, codes_r, FC_MODE_SW);
	assign h_son        = hit(lvl, codes_r, FC_SERVO_ON);
	assign h_spd_dir    = hit(lvl, codes_r, FC_SPD_DIR);
	assign h_zhold      = hit(lvl, codes_r, FC_ZERO_HOLD);
	assign h_trq_dir    = hit(lvl, codes_r, FC_TRQ_DIR);
	assign h_pos_dir    = hit(lvl, codes_r, FC_POS_DIR);
	assign h_fault_rise = hit(rise, codes_r, FC_FAULT_CLR);
	assign h_probe_rise = hit(rise, codes_r, FC_PROBE);
	assign h_fwd_rise   = hit(rise, codes_r, FC_FWD_OFS);
	assign h_rev_rise   = hit(rise, codes_r, FC_REV_OFS);

	// with no switch terminal assigned the inactive-level meaning holds
	always_comb begin
		if (h_sw_any && h_sw) begin
			mode_nxt = to_mode(mode_select_param_in[MODE_ON_LSB +: 2]); // RULE4
		end else begin
			mode_nxt = to_mode(mode_select_param_in[MODE_OFF_LSB +: 2]); // RULE4
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_r <= RST_MODE;
		end else begin
			mode_r <= mode_nxt; // RULE4
		end
	end

	assign ctrl_mode_out = mode_r;
	assign in_p = (mode_r == DIFM_POS);
	assign in_s = (mode_r == DIFM_SPD);
	assign in_t = (mode_r == DIFM_TRQ);

	// level functions, gated by the modes in which each applies
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			servo_enable_out    <= 1'b0;
			internal_cmd_out    <= 4'h0;
			pulse_inhibit_out   <= 1'b0;
			fwd_inhibit_out     <= 1'b0;
			rev_inhibit_out     <= 1'b0;
			gain_sel_out        <= 1'b0;
			inertia_sel_out     <= 1'b0;
			jog_fwd_out         <= 1'b0;
			jog_rev_out         <= 1'b0;
			gear_num_sel_out    <= 2'h0;
			torque_limit_out    <= 1'b0;
			estop_out           <= 1'b0;
		end else begin
			servo_enable_out    <= h_son; // RULE13
			for (int b = 0; b < 4; b++) begin
				internal_cmd_out[b] <= (in_p | in_s) &
					hit(lvl, codes_r, FC_CMD0 + difm_code_t'(b)); // RULE13
			end
			pulse_inhibit_out   <= in_p & hit(lvl, codes_r, FC_PUL_INH); // RULE13
			fwd_inhibit_out     <= hit(lvl, codes_r, FC_FWD_INH); // RULE13
			rev_inhibit_out     <= hit(lvl, codes_r, FC_REV_INH); // RULE13
			gain_sel_out        <= hit(lvl, codes_r, FC_GAIN_SEL); // RULE13
			inertia_sel_out     <= hit(lvl, codes_r, FC_INERT_SEL); // RULE13
			jog_fwd_out         <= in_s & hit(lvl, codes_r, FC_JOG_FWD); // RULE13
			jog_rev_out         <= in_s & hit(lvl, codes_r, FC_JOG_REV); // RULE13
			gear_num_sel_out[0] <= in_p & hit(lvl, codes_r, FC_GEAR0); // RULE13
			gear_num_sel_out[1] <= in_p & hit(lvl, codes_r, FC_GEAR1); // RULE13
			torque_limit_out    <= hit(lvl, codes_r, FC_TRQ_LIM); // RULE13
			estop_out           <= hit(lvl, codes_r, FC_ESTOP); // RULE13
		end
	end

	// direction and clamp selects
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			speed_dir_invert_out  <= 1'b0;
			zero_speed_hold_out   <= 1'b0;
			torque_dir_invert_out <= 1'b0;
			pos_dir_invert_out    <= 1'b0;
		end else begin
			speed_dir_invert_out  <= in_s & h_spd_dir; // RULE3
			zero_speed_hold_out   <= in_s & h_zhold; // RULE5
			torque_dir_invert_out <= in_t & h_trq_dir; // RULE6
			pos_dir_invert_out    <= in_p & h_pos_dir; // RULE7
		end
	end

	// edge functions: one-cycle pulses, so a held terminal acts only once
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fault_clear_out   <= 1'b0;
			cmd_trigger_out   <= 1'b0;
			ext_det_rise_out  <= 1'b0;
			ext_det_fall_out  <= 1'b0;
			home_start_out    <= 1'b0;
			probe_capture_out <= 1'b0;
			fwd_offset_out    <= 1'b0;
			rev_offset_out    <= 1'b0;
		end else begin
			fault_clear_out   <= h_fault_rise; // RULE2
			cmd_trigger_out   <= in_p & hit(rise, codes_r, FC_CMD_TRIG); // RULE12
			ext_det_rise_out  <= hit(rise, codes_r, FC_EXT_DET); // RULE12
			ext_det_fall_out  <= hit(fall, codes_r, FC_EXT_DET); // RULE12
			home_start_out    <= hit(rise, codes_r, FC_HOME); // RULE12
			probe_capture_out <= h_probe_rise; // RULE8
			fwd_offset_out    <= in_p & h_fwd_rise; // RULE9
			rev_offset_out    <= in_p & h_rev_rise; // RULE10
		end
	end

	// position error clear trigger style comes from a drive setting
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pos_err_clear_out <= 1'b0;
		end else if (pos_clear_level_in) begin
			pos_err_clear_out <= in_p & hit(lvl, codes_r, FC_POS_CLR);
		end else begin
			pos_err_clear_out <= in_p & hit(rise, codes_r, FC_POS_CLR);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence fault_edge_s;
		h_fault_rise;
	endsequence
	sequence one_pulse_s;
		fault_clear_out ##1 !fault_clear_out;
	endsequence

	fault_clear_edge_a: assert property (fault_edge_s |=> one_pulse_s) // RULE2
		else $error("fault clear pulse missing or stretched");
	default_codes_a: assert property ($rose(rst_b_in) |-> codes_r == DEF_CODES) // RULE11
		else $error("terminal codes not at defaults after reset");
	speed_dir_a: assert property (
		speed_dir_invert_out == ($past(mode_r) == DIFM_SPD && $past(h_spd_dir))) // RULE3
		else $error("speed direction select wrong");
	mode_switch_a: assert property ((h_sw_any && h_sw && // RULE4
		mode_select_param_in[MODE_ON_LSB +: 2] == 2'h2) |=> mode_r == DIFM_TRQ)
		else $error("mode switch did not select active-level mode");
	zero_hold_a: assert property (!in_s |=> !zero_speed_hold_out) // RULE5
		else $error("zero speed hold outside speed mode");
	torque_dir_a: assert property ((in_t && h_trq_dir) |=> torque_dir_invert_out) // RULE6
		else $error("torque direction not inverted");
	pos_dir_a: assert property (
		pos_dir_invert_out == ($past(in_p) && $past(h_pos_dir))) // RULE7
		else $error("position direction select wrong");
	probe_edge_a: assert property (h_probe_rise |=> probe_capture_out) // RULE8
		else $error("probe capture missing");
	fwd_offset_a: assert property ((h_fwd_rise && in_p) |=> fwd_offset_out ##1 !fwd_offset_out) // RULE9
		else $error("forward offset pulse wrong");
	rev_offset_a: assert property (!in_p |=> !rev_offset_out) // RULE10
		else $error("reverse offset outside position mode");
	servo_level_a: assert property (servo_enable_out == $past(h_son)) // RULE13
		else $error("servo enable does not follow terminal");
	disabled_code_a: assert property ( // RULE1
		!hit({NUM_TERM{1'b1}}, codes_r, FC_SERVO_ON) |=> !servo_enable_out)
		else $error("servo enable without a servo enable terminal");
endmodule // difm_top

// File: verif/difm_host_model.sv
// upper controller model that drives the isolated input terminals
module difm_host_model
	import difm_pkg::*;
(
	input  wire logic                          clk_in,
	output logic      [difm_pkg::NUM_TERM-1:0] term_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial term_out = '0;

	// levels change just after an edge and then hold until the next call
	task automatic drive(input logic [NUM_TERM-1:0] lvl);
		@(posedge clk_in);
		term_out <= lvl;
	endtask
endmodule // difm_host_model

// File: verif/difm_top_test.sv
// self-checking bench for the digital input function map
module difm_top_test
	import difm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [5:0] DEFS [8] = '{6'h01, 6'h02, 6'h0D, 6'h0E, 6'h03, 6'h0C, 6'h14, 6'h15};
	localparam logic [5:0] MAP [8]  = '{6'h22, 6'h24, 6'h0A, 6'h04, 6'h0B, 6'h13, 6'h21, 6'h23};

	logic                clk_in;
	logic                rst_b_in;
	logic [NUM_TERM-1:0] term;
	logic                code_wr;
	logic [2:0]          code_idx;
	difm_code_t          code_data;
	logic [3:0]          mode_sel;
	logic                pclr;
	difm_code_t          code_rd;
	difm_mode_t          mode;
	logic                servo_en;
	logic                fault_clr;
	logic                spd_dir;
	logic                zhold;
	logic                tq_dir;
	logic                pos_dir;
	logic                probe;
	logic                fwd_ofs;
	logic                rev_ofs;
	logic                pos_clr;
	logic [3:0]          icmd;
	logic                ctrig;
	logic                pinh;
	logic                fwd_inh;
	logic                rev_inh;
	logic                gain;
	logic                inert;
	logic                jog_f;
	logic                jog_r;
	logic [1:0]          gear;
	logic                ext_r;
	logic                ext_f;
	logic                home;
	logic                tlim;
	logic                estop;
	int                  n_errors;
	int                  cmp_count;
	int                  cyc;
	int                  pcnt [9];

	difm_host_model u_host (.clk_in(clk_in), .term_out(term));

	difm_top u_dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .input_terminal_in(term),
		.code_wr_in(code_wr), .code_idx_in(code_idx), .code_data_in(code_data),
		.mode_select_param_in(mode_sel), .pos_clear_level_in(pclr),
		.code_rd_out(code_rd), .ctrl_mode_out(mode), .servo_enable_out(servo_en),
		.fault_clear_out(fault_clr), .pos_err_clear_out(pos_clr),
		.speed_dir_invert_out(spd_dir), .internal_cmd_out(icmd), .cmd_trigger_out(ctrig),
		.zero_speed_hold_out(zhold), .pulse_inhibit_out(pinh), .fwd_inhibit_out(fwd_inh),
		.rev_inhibit_out(rev_inh), .gain_sel_out(gain), .inertia_sel_out(inert),
		.jog_fwd_out(jog_f), .jog_rev_out(jog_r), .torque_dir_invert_out(tq_dir),
		.gear_num_sel_out(gear), .ext_det_rise_out(ext_r), .ext_det_fall_out(ext_f),
		.home_start_out(home), .torque_limit_out(tlim), .estop_out(estop),
		.pos_dir_invert_out(pos_dir),
		.probe_capture_out(probe), .fwd_offset_out(fwd_ofs), .rev_offset_out(rev_ofs)
	);

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// a hung handshake would otherwise stall the run forever
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		cmp_count++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// pulses are counted over a window, so a held level that fires twice is caught
	task automatic run(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#1;
			pcnt[0] += int'(fault_clr === 1'b1);
			pcnt[1] += int'(probe === 1'b1);
			pcnt[2] += int'(fwd_ofs === 1'b1);
			pcnt[3] += int'(rev_ofs === 1'b1);
			pcnt[4] += int'(ctrig === 1'b1);
			pcnt[5] += int'(ext_r === 1'b1);
			pcnt[6] += int'(ext_f === 1'b1);
			pcnt[7] += int'(home === 1'b1);
			pcnt[8] += int'(pos_clr === 1'b1);
		end
	endtask

	task automatic wr_code(input logic [2:0] idx, input logic [5:0] data);
		@(posedge clk_in);
		code_wr   <= 1'b1;
		code_idx  <= idx;
		code_data <= data;
		@(posedge clk_in);
		code_wr <= 1'b0;
	endtask

	// terminal 8 code in the top field, terminal 1 code in the bottom field
	task automatic wr_all(input logic [47:0] c);
		for (int i = 0; i < 8; i++) wr_code(3'(i), c[i*6 +: 6]);
	endtask

	task automatic t_defaults();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			code_idx <= 3'(i);
			run(2);
			chk("default code", {2'h0, DEFS[i]}, {2'h0, code_rd});
		end
	endtask

	task automatic t_level_and_off();
		u_host.drive(8'h01);
		run(4);
		chk("servo on", 8'h01, {7'h00, servo_en});
		u_host.drive(8'h00);
		run(4);
		chk("servo off", 8'h00, {7'h00, servo_en});
		wr_code(3'h0, 6'h00);
		u_host.drive(8'h01);
		run(4);
		chk("disabled terminal", 8'h00, {7'h00, servo_en});
		u_host.drive(8'h00);
		run(3);
	endtask

	task automatic t_fault_edge();
		u_host.drive(8'h02);
		run(8);
		chk_cnt("fault clear pulses", 1, pcnt[0]);
		u_host.drive(8'h00);
		run(4);
		chk_cnt("fault clear on fall", 1, pcnt[0]);
	endtask

	task automatic t_remap();
		for (int i = 0; i < 8; i++) wr_code(3'(i), MAP[i]);
		@(posedge clk_in);
		code_idx <= 3'h7;
		mode_sel <= 4'h4;
		run(3);
		chk("written code", 8'h23, {2'h0, code_rd});
	endtask

	task automatic t_pos_mode();
		u_host.drive(8'hF8);
		run(6);
		chk("pos mode", 8'h00, {6'h00, mode});
		chk("pos dir", 8'h01, {7'h00, pos_dir});
		chk("spd dir gated", 8'h00, {7'h00, spd_dir});
		chk("zero hold gated", 8'h00, {7'h00, zhold});
		chk("trq dir gated", 8'h00, {7'h00, tq_dir});
		chk_cnt("fwd offset", 1, pcnt[2]);
		u_host.drive(8'hFA);
		run(6);
		chk_cnt("rev offset", 1, pcnt[3]);
		u_host.drive(8'h00);
		run(6);
		chk_cnt("fwd on fall", 1, pcnt[2]);
		chk_cnt("rev on fall", 1, pcnt[3]);
		chk("pos dir off", 8'h00, {7'h00, pos_dir});
		u_host.drive(8'h01);
		run(6);
		chk_cnt("probe pos", 1, pcnt[1]);
		u_host.drive(8'h00);
		run(4);
	endtask

	task automatic t_spd_trq_mode();
		u_host.drive(8'h04);
		run(6);
		chk("spd mode", 8'h01, {6'h00, mode});
		u_host.drive(8'hFC);
		run(6);
		chk("spd dir", 8'h01, {7'h00, spd_dir});
		chk("zero hold", 8'h01, {7'h00, zhold});
		chk("trq dir gated", 8'h00, {7'h00, tq_dir});
		chk("pos dir gated", 8'h00, {7'h00, pos_dir});
		chk_cnt("fwd gated", 1, pcnt[2]);
		u_host.drive(8'hFD);
		run(6);
		chk_cnt("probe spd", 2, pcnt[1]);
		@(posedge clk_in);
		mode_sel <= 4'h8;
		run(8);
		chk("trq mode", 8'h02, {6'h00, mode});
		chk("trq dir", 8'h01, {7'h00, tq_dir});
		chk("spd dir off", 8'h00, {7'h00, spd_dir});
		chk("zero hold off", 8'h00, {7'h00, zhold});
	endtask

	// command bits, trigger, inhibit, detector and both position clear styles
	task automatic t_cmd_codes();
		u_host.drive(8'h00);
		run(3);
		wr_all({6'h16, 6'h09, 6'h03, 6'h0C, 6'h08, 6'h07, 6'h06, 6'h05});
		u_host.drive(8'hFF);
		run(6);
		chk("mode back to pos", 8'h00, {6'h00, mode});
		chk("internal cmd", 8'h0F, {4'h0, icmd});
		chk("pulse inhibit", 8'h01, {7'h00, pinh});
		chk_cnt("cmd trigger", 1, pcnt[4]);
		chk_cnt("ext rise", 1, pcnt[5]);
		chk_cnt("pos clear edge", 1, pcnt[8]);
		u_host.drive(8'h00);
		run(6);
		chk("internal cmd off", 8'h00, {4'h0, icmd});
		chk_cnt("ext fall", 1, pcnt[6]);
		chk_cnt("ext rise on fall", 1, pcnt[5]);
		@(posedge clk_in);
		pclr <= 1'b1;
		u_host.drive(8'hFF);
		run(6);
		chk("pos clear level", 8'h01, {7'h00, pos_clr});
		chk_cnt("cmd trigger again", 2, pcnt[4]);
		u_host.drive(8'h00);
		run(4);
		chk("pos clear released", 8'h00, {7'h00, pos_clr});
		@(posedge clk_in);
		mode_sel <= 4'h1;
		u_host.drive(8'hFF);
		run(6);
		chk("spd mode no switch", 8'h01, {6'h00, mode});
		chk("internal cmd spd", 8'h0F, {4'h0, icmd});
		chk("pulse inhibit gated", 8'h00, {7'h00, pinh});
		chk("pos clear gated", 8'h00, {7'h00, pos_clr});
		chk_cnt("cmd trigger gated", 2, pcnt[4]);
		chk_cnt("ext rise spd", 3, pcnt[5]);
		u_host.drive(8'h00);
		run(4);
	endtask

	// overtravel, gain, inertia, jog, gear, homing, torque limit and stop codes
	task automatic t_level_codes();
		wr_all({6'h15, 6'h14, 6'h12, 6'h11, 6'h10, 6'h0F, 6'h0E, 6'h0D});
		u_host.drive(8'hFF);
		run(6);
		chk("fwd inhibit", 8'h01, {7'h00, fwd_inh});
		chk("rev inhibit", 8'h01, {7'h00, rev_inh});
		chk("gain select", 8'h01, {7'h00, gain});
		chk("inertia select", 8'h01, {7'h00, inert});
		chk("jog fwd", 8'h01, {7'h00, jog_f});
		chk("jog rev", 8'h01, {7'h00, jog_r});
		chk("gear gated", 8'h00, {6'h00, gear});
		@(posedge clk_in);
		mode_sel <= 4'h0;
		run(4);
		chk("gear select", 8'h03, {6'h00, gear});
		chk("jog gated", 8'h00, {6'h00, jog_f, jog_r});
		chk("gain pos", 8'h01, {7'h00, gain});
		u_host.drive(8'h00);
		run(4);
		chk("level codes off", 8'h00, {4'h0, fwd_inh, rev_inh, gain, inert});
		wr_all({6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h19, 6'h18, 6'h17});
		u_host.drive(8'h07);
		run(6);
		chk_cnt("home start", 1, pcnt[7]);
		chk("torque limit", 8'h01, {7'h00, tlim});
		chk("estop", 8'h01, {7'h00, estop});
		u_host.drive(8'h00);
		run(4);
		chk_cnt("home on fall", 1, pcnt[7]);
		chk("limit and stop off", 8'h00, {6'h00, tlim, estop});
	endtask

	initial begin
		rst_b_in  = 1'b0;
		code_wr   = 1'b0;
		code_idx  = 3'h0;
		code_data = 6'h00;
		mode_sel  = 4'h0;
		pclr      = 1'b0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_defaults();
		t_level_and_off();
		t_fault_edge();
		t_remap();
		t_pos_mode();
		t_spd_trq_mode();
		t_cmd_codes();
		t_level_codes();
		finish_test();
	end
endmodule // difm_top_test
